// ===== src/eeprom_defines.svh
// constants shared by both ends of the serial data memory link
// assumes the includer compiles it once per unit; guard protects repeats
`ifndef EEPROM_DEFINES_SVH
`define EEPROM_DEFINES_SVH

// ----------------------------------------------------------------
// geometry and control byte layout
// ----------------------------------------------------------------
`define EE_ADDR_W 4
`define EE_DATA_W 8
`define CTRL_TYPE_MSB 7
`define CTRL_TYPE_LSB 4
`define CTRL_RW_BIT 0
`define CTRL_SPARE_BITS 3'h0
`define RW_READ 1'b1
`define LAST_BIT 3'h7
`define ACK_SLOT 4'h8
// arbitrary device-type value, not a real part's code
`define TYPE_CODE_DEF 4'h5

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define MCLK_PERIOD_NS 50
`define SCL_PERIOD_NS 10000
`define WR_CYCLE_NS 4000000
`define WR_CYCLE_CYC (`WR_CYCLE_NS / `MCLK_PERIOD_NS)
`define QTR_CYC (`SCL_PERIOD_NS / 4 / `MCLK_PERIOD_NS)

`endif

// ===== src/eeprom_pkg.sv
// types shared by the serial memory slave and its bus master
// assumes nothing beyond a SystemVerilog compiler
package eeprom_pkg;

    // nine states: three bits would not hold them
    typedef enum logic [3:0] {
        D_IDLE, D_CTRL, D_ADDR, D_DATA, D_CACK, D_AACK, D_DACK, D_SEND, D_RACK
    } dev_state_type;

    typedef enum logic [1:0] {M_IDLE, M_START, M_BIT, M_STOP} mst_state_type;

    typedef enum logic [2:0] {S_CTRL, S_ADDR, S_DATA, S_CTRLR, S_READ} mst_stage_type;

    typedef enum logic [1:0] {CMD_WRITE, CMD_READ_CUR, CMD_READ_RAND, CMD_POLL} cmd_type;

endpackage

// ===== src/i2c_link_if.sv
// two-wire link between bus master and serial memory slave
// assumes an external pull-up: the wire is high unless someone pulls it low
`timescale 1ns/1ps
`default_nettype none

interface i2c_link_if;
    logic scl;
    logic sda_m_out;
    logic sda_m_oe;
    logic sda_d_out;
    logic sda_d_oe;
    logic sda;

    // open-drain wired and with pull-up
    assign sda = ~((sda_m_oe & ~sda_m_out) | (sda_d_oe & ~sda_d_out));

    modport device (input scl, input sda, output sda_d_out, output sda_d_oe);
    modport host (output scl, input sda, output sda_m_out, output sda_m_oe);
endinterface

`default_nettype wire

// ===== src/eeprom_slave.sv
// serial data memory slave: ack polling, byte write, three read forms
// assumes scl comes from the master and parks high between frames
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_defines.svh"

module eeprom_slave #(
    parameter int unsigned WR_CYCLES = `WR_CYCLE_CYC,
    parameter int unsigned ADDR_W = `EE_ADDR_W,
    parameter logic [3:0] TYPE_CODE = `TYPE_CODE_DEF
) (
    input wire logic mclk_i,    // core clock
    input wire logic rst_n_i,   // reset, active low
    i2c_link_if.device link,    // two-wire bus
    output logic busy_o         // internal write cycle running
);

    // ----------------------------------------------------------------
    // parameter checks
    // ----------------------------------------------------------------
    if (WR_CYCLES < 1 || ADDR_W < 1 || ADDR_W > `EE_DATA_W) begin : g_chk
        $error("eeprom_slave: unsupported parameters");
    end

    localparam int unsigned DEPTH = 1 << ADDR_W;

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic [`EE_DATA_W-1:0] mem_q [DEPTH];
    logic start_tgl_q;
    logic stop_tgl_q;
    logic start_seen_q;
    logic bit_q;
    logic busy_s1_q;
    logic busy_s2_q;
    eeprom_pkg::dev_state_type state_q;
    logic [2:0] cnt_q;
    logic [`EE_DATA_W-1:0] sh_q;
    logic [`EE_DATA_W-1:0] tx_q;
    logic [ADDR_W-1:0] ptr_q;
    logic rw_q;
    logic oe_q;
    logic wr_ok_q;
    logic [ADDR_W-1:0] wr_addr_q;
    logic [`EE_DATA_W-1:0] wr_data_q;
    logic stop_s1_q;
    logic stop_s2_q;
    logic stop_s3_q;
    logic busy_q;
    logic [31:0] tmr_q;
    logic stop_ev;
    logic [`EE_DATA_W-1:0] byte_w;
    logic [`EE_DATA_W-1:0] rd_byte;

    assign byte_w = {sh_q[`EE_DATA_W-2:0], bit_q};
    // memory only changes on the edge that starts a write cycle, and no read is acked during the cycle
    assign rd_byte = mem_q[ptr_q];
    assign stop_ev = stop_s2_q ^ stop_s3_q;

    // ----------------------------------------------------------------
    // start and stop detection on data edges
    // ----------------------------------------------------------------
    // async reset: these clocks do not run while reset is held
    always_ff @(negedge link.sda or negedge rst_n_i) begin
        if (!rst_n_i) begin
            start_tgl_q <= 1'b0;
        end else if (link.scl) begin
            start_tgl_q <= ~start_tgl_q;
        end
    end

    always_ff @(posedge link.sda or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stop_tgl_q <= 1'b0;
        end else if (link.scl) begin
            stop_tgl_q <= ~stop_tgl_q;
        end
    end

    // ----------------------------------------------------------------
    // bit sampling on rising clock
    // ----------------------------------------------------------------
    always_ff @(posedge link.scl or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bit_q <= 1'b1;
        end else begin
            bit_q <= link.sda;
        end
    end

    always_ff @(posedge link.scl or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy_s1_q <= 1'b0;
            busy_s2_q <= 1'b0;
        end else begin
            busy_s1_q <= busy_q;
            busy_s2_q <= busy_s1_q;
        end
    end

    // ----------------------------------------------------------------
    // protocol engine on falling clock
    // ----------------------------------------------------------------
    always_ff @(negedge link.scl or negedge rst_n_i) begin
        if (!rst_n_i) begin
            start_seen_q <= 1'b0;
            state_q <= eeprom_pkg::D_IDLE;
            cnt_q <= '0;
            sh_q <= '0;
            tx_q <= '0;
            ptr_q <= '0;
            rw_q <= 1'b0;
            oe_q <= 1'b0;
            wr_ok_q <= 1'b0;
            wr_addr_q <= '0;
            wr_data_q <= '0;
        end else if (start_tgl_q != start_seen_q) begin
            // first fall after a start: a new control byte follows
            start_seen_q <= ~start_seen_q;
            state_q <= eeprom_pkg::D_CTRL;
            cnt_q <= '0;
            oe_q <= 1'b0;
            wr_ok_q <= 1'b0;
        end else begin
            case (state_q)
                eeprom_pkg::D_CTRL, eeprom_pkg::D_ADDR, eeprom_pkg::D_DATA: begin
                    sh_q <= byte_w;
                    cnt_q <= cnt_q + 3'h1;
                    if (state_q == eeprom_pkg::D_DATA && cnt_q == '0) begin
                        // extra data byte drops the one held; a short one aborts
                        wr_ok_q <= 1'b0;
                    end
                    if (cnt_q == `LAST_BIT) begin
                        cnt_q <= '0;
                        if (state_q == eeprom_pkg::D_CTRL) begin
                            if (byte_w[`CTRL_TYPE_MSB:`CTRL_TYPE_LSB] == TYPE_CODE
                                    && !busy_s2_q) begin
                                oe_q <= 1'b1;
                                rw_q <= byte_w[`CTRL_RW_BIT];
                                state_q <= eeprom_pkg::D_CACK;
                            end else begin
                                state_q <= eeprom_pkg::D_IDLE;
                            end
                        end else if (state_q == eeprom_pkg::D_ADDR) begin
                            ptr_q <= byte_w[ADDR_W-1:0];
                            oe_q <= 1'b1;
                            state_q <= eeprom_pkg::D_AACK;
                        end else begin
                            wr_data_q <= byte_w;
                            wr_addr_q <= ptr_q;
                            wr_ok_q <= 1'b1;
                            oe_q <= 1'b1;
                            state_q <= eeprom_pkg::D_DACK;
                        end
                    end
                end
                eeprom_pkg::D_CACK: begin
                    cnt_q <= '0;
                    if (rw_q == `RW_READ) begin
                        // current address read: pointer is past the last byte read, or at the last written address
                        tx_q <= {rd_byte[`EE_DATA_W-2:0], 1'b0};
                        oe_q <= ~rd_byte[`EE_DATA_W-1];
                        state_q <= eeprom_pkg::D_SEND;
                    end else begin
                        oe_q <= 1'b0;
                        state_q <= eeprom_pkg::D_ADDR;
                    end
                end
                eeprom_pkg::D_AACK, eeprom_pkg::D_DACK: begin
                    oe_q <= 1'b0;
                    cnt_q <= '0;
                    state_q <= eeprom_pkg::D_DATA;
                end
                eeprom_pkg::D_SEND: begin
                    if (cnt_q == `LAST_BIT) begin
                        oe_q <= 1'b0;
                        ptr_q <= ptr_q + 1'b1;
                        state_q <= eeprom_pkg::D_RACK;
                    end else begin
                        oe_q <= ~tx_q[`EE_DATA_W-1];
                        tx_q <= {tx_q[`EE_DATA_W-2:0], 1'b0};
                        cnt_q <= cnt_q + 3'h1;
                    end
                end
                eeprom_pkg::D_RACK: begin
                    cnt_q <= '0;
                    if (!bit_q) begin
                        tx_q <= {rd_byte[`EE_DATA_W-2:0], 1'b0};
                        oe_q <= ~rd_byte[`EE_DATA_W-1];
                        state_q <= eeprom_pkg::D_SEND;
                    end else begin
                        // nack: leave the line high for the stop
                        oe_q <= 1'b0;
                        state_q <= eeprom_pkg::D_IDLE;
                    end
                end
                default: begin
                    oe_q <= 1'b0;
                    state_q <= eeprom_pkg::D_IDLE;
                end
            endcase
        end
    end

    assign link.sda_d_out = 1'b0;
    assign link.sda_d_oe = oe_q;

    // ----------------------------------------------------------------
    // stop event into the core clock
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            stop_s1_q <= 1'b0;
            stop_s2_q <= 1'b0;
            stop_s3_q <= 1'b0;
        end else begin
            stop_s1_q <= stop_tgl_q;
            stop_s2_q <= stop_s1_q;
            stop_s3_q <= stop_s2_q;
        end
    end

    // ----------------------------------------------------------------
    // self-timed write cycle
    // ----------------------------------------------------------------
    // write fields are quiet here: scl parks after the stop
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            busy_q <= 1'b0;
            tmr_q <= '0;
        end else if (busy_q) begin
            if (tmr_q == WR_CYCLES - 1) begin
                busy_q <= 1'b0;
            end else begin
                tmr_q <= tmr_q + 32'h1;
            end
        end else if (stop_ev && wr_ok_q) begin
            busy_q <= 1'b1;
            tmr_q <= '0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else if (stop_ev && wr_ok_q && !busy_q) begin
            mem_q[wr_addr_q] <= wr_data_q;
        end
    end

    assign busy_o = busy_q;

endmodule

`default_nettype wire

// ===== src/eeprom_master.sv
// two-wire bus master issuing write, poll and read commands
// assumes user commands arrive on mclk; it makes scl by dividing mclk
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_defines.svh"

module eeprom_master #(
    parameter int unsigned QTR = `QTR_CYC,
    parameter int unsigned ADDR_W = `EE_ADDR_W,
    parameter logic [3:0] TYPE_CODE = `TYPE_CODE_DEF
) (
    input wire logic mclk_i,                 // core clock
    input wire logic rst_n_i,                // reset, active low
    i2c_link_if.host link,                   // two-wire bus
    input wire logic cmd_valid_i,            // command request
    input wire eeprom_pkg::cmd_type cmd_i,   // command kind
    input wire logic [ADDR_W-1:0] addr_i,    // word address
    input wire logic [`EE_DATA_W-1:0] wdata_i, // write data
    input wire logic [ADDR_W-1:0] rd_len_i,  // read bytes minus one
    output logic cmd_ready_o,                // idle, takes a command
    output logic [`EE_DATA_W-1:0] rdata_o,   // received byte
    output logic rdata_valid_o,              // pulse per read byte
    output logic done_o                      // pulse after stop
);

    if (QTR < 1 || ADDR_W < 1 || ADDR_W > `EE_DATA_W) begin : g_chk
        $error("eeprom_master: unsupported parameters");
    end

    eeprom_pkg::mst_state_type state_q;
    eeprom_pkg::mst_stage_type stage_q;
    eeprom_pkg::cmd_type cmd_q;
    logic [31:0] qcnt_q;
    logic [1:0] ph_q;
    logic [3:0] bitn_q;
    logic [`EE_DATA_W-1:0] tx_q;
    logic [`EE_DATA_W-1:0] rx_q;
    logic [ADDR_W-1:0] addr_q;
    logic [`EE_DATA_W-1:0] wdata_q;
    logic [ADDR_W-1:0] left_q;
    logic scl_q;
    logic oe_q;
    logic sda_s1_q;
    logic sda_s2_q;
    logic tick;

    assign tick = (qcnt_q == QTR - 1);

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
        end else begin
            sda_s1_q <= link.sda;
            sda_s2_q <= sda_s1_q;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i || state_q == eeprom_pkg::M_IDLE || tick) begin
            qcnt_q <= '0;
        end else begin
            qcnt_q <= qcnt_q + 32'h1;
        end
    end

    // ----------------------------------------------------------------
    // bit sequencer: each bit is four quarter periods
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        rdata_valid_o <= 1'b0;
        done_o <= 1'b0;
        if (!rst_n_i) begin
            state_q <= eeprom_pkg::M_IDLE;
            stage_q <= eeprom_pkg::S_CTRL;
            cmd_q <= eeprom_pkg::CMD_WRITE;
            ph_q <= '0;
            bitn_q <= '0;
            tx_q <= '0;
            rx_q <= '0;
            addr_q <= '0;
            wdata_q <= '0;
            left_q <= '0;
            scl_q <= 1'b1;
            oe_q <= 1'b0;
            cmd_ready_o <= 1'b1;
            rdata_o <= '0;
            rdata_valid_o <= 1'b0;
            done_o <= 1'b0;
        end else if (state_q == eeprom_pkg::M_IDLE) begin
            ph_q <= '0;
            if (cmd_valid_i) begin
                cmd_q <= cmd_i;
                addr_q <= addr_i;
                wdata_q <= wdata_i;
                left_q <= rd_len_i;
                cmd_ready_o <= 1'b0;
                stage_q <= eeprom_pkg::S_CTRL;
                state_q <= eeprom_pkg::M_START;
            end
        end else if (tick) begin
            ph_q <= ph_q + 2'h1;
            case (ph_q)
                2'h0: scl_q <= 1'b0;
                2'h1: begin
                    if (state_q == eeprom_pkg::M_START) begin
                        oe_q <= 1'b0;
                    end else if (state_q == eeprom_pkg::M_STOP) begin
                        oe_q <= 1'b1;
                    end else if (stage_q == eeprom_pkg::S_READ) begin
                        // ack while more bytes wanted, nack on the last
                        oe_q <= (bitn_q == `ACK_SLOT) && (left_q != '0);
                    end else begin
                        oe_q <= (bitn_q != `ACK_SLOT) && !tx_q[`EE_DATA_W-1];
                    end
                end
                2'h2: scl_q <= 1'b1;
                default: begin
                    case (state_q)
                        eeprom_pkg::M_START: begin
                            oe_q <= 1'b1;
                            bitn_q <= '0;
                            state_q <= eeprom_pkg::M_BIT;
                            tx_q <= {TYPE_CODE, `CTRL_SPARE_BITS,
                                     stage_q == eeprom_pkg::S_CTRLR || cmd_q == eeprom_pkg::CMD_READ_CUR};
                        end
                        eeprom_pkg::M_STOP: begin
                            oe_q <= 1'b0;
                            state_q <= eeprom_pkg::M_IDLE;
                            cmd_ready_o <= 1'b1;
                            done_o <= 1'b1;
                        end
                        default: begin
                            if (bitn_q != `ACK_SLOT) begin
                                rx_q <= {rx_q[`EE_DATA_W-2:0], sda_s2_q};
                                tx_q <= {tx_q[`EE_DATA_W-2:0], 1'b0};
                                bitn_q <= bitn_q + 4'h1;
                            end else begin
                                bitn_q <= '0;
                                case (stage_q)
                                    eeprom_pkg::S_CTRL, eeprom_pkg::S_CTRLR: begin
                                        if (sda_s2_q) begin
                                            state_q <= eeprom_pkg::M_START;
                                        end else if (stage_q == eeprom_pkg::S_CTRLR
                                                || cmd_q == eeprom_pkg::CMD_READ_CUR) begin
                                            stage_q <= eeprom_pkg::S_READ;
                                        end else if (cmd_q == eeprom_pkg::CMD_POLL) begin
                                            state_q <= eeprom_pkg::M_STOP;
                                        end else begin
                                            stage_q <= eeprom_pkg::S_ADDR;
                                            tx_q <= `EE_DATA_W'(addr_q);
                                        end
                                    end
                                    eeprom_pkg::S_ADDR: begin
                                        if (cmd_q == eeprom_pkg::CMD_WRITE) begin
                                            stage_q <= eeprom_pkg::S_DATA;
                                            tx_q <= wdata_q;
                                        end else begin
                                            stage_q <= eeprom_pkg::S_CTRLR;
                                            state_q <= eeprom_pkg::M_START;
                                        end
                                    end
                                    eeprom_pkg::S_READ: begin
                                        rdata_o <= rx_q;
                                        rdata_valid_o <= 1'b1;
                                        left_q <= left_q - 1'b1;
                                        if (left_q == '0) begin
                                            state_q <= eeprom_pkg::M_STOP;
                                        end
                                    end
                                    default: state_q <= eeprom_pkg::M_STOP;
                                endcase
                            end
                        end
                    endcase
                end
            endcase
        end
    end

    assign link.scl = scl_q;
    assign link.sda_m_out = 1'b0;
    assign link.sda_m_oe = oe_q;

endmodule

`default_nettype wire

// ===== tb/eeprom_link_checker.sv
// assertions on the two-wire link between master and memory slave
// assumes scl comes from the master and both ends share mclk and reset
`timescale 1ns/1ps
`default_nettype none

module eeprom_link_checker #(
    parameter int unsigned WR_CYCLES = 50
) (
    input wire logic mclk_i,    // core clock
    input wire logic rst_n_i,   // reset, active low
    input wire logic scl,       // link clock
    input wire logic sda,       // resolved data line
    input wire logic sda_d_oe,  // slave pulls low
    input wire logic busy_o     // write cycle running
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    logic [31:0] busy_cnt_q;

    // ----------------------------------------------------------------
    // helper: length of the running write cycle
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i || !busy_o) begin
            busy_cnt_q <= 32'h0;
        end else begin
            busy_cnt_q <= busy_cnt_q + 32'h1;
        end
    end

    property p_no_ack_busy; busy_o |-> !sda_d_oe; endproperty
    a_no_ack_busy: assert property (p_no_ack_busy) else $error("slave drove sda while busy");
    property p_busy_len; $fell(busy_o) |-> busy_cnt_q == WR_CYCLES; endproperty
    a_busy_len: assert property (p_busy_len) else $error("write cycle length wrong");
    property p_busy_after_stop; $rose(busy_o) |-> $past(scl) && $past(sda); endproperty
    a_busy_after_stop: assert property (p_busy_after_stop) else $error("write cycle began off a stop");
    property p_busy_holds; $rose(busy_o) |=> busy_o [*8]; endproperty
    a_busy_holds: assert property (p_busy_holds) else $error("write cycle cut short");
    property p_oe_scl_low; $changed(sda_d_oe) |-> !scl; endproperty
    a_oe_scl_low: assert property (p_oe_scl_low) else $error("slave changed sda with scl high");
    property p_ack_holds; ($rose(scl) && sda_d_oe) |-> sda_d_oe [*4]; endproperty
    a_ack_holds: assert property (p_ack_holds) else $error("slave bit not stable over scl high");
    property p_release_after_stop; (scl && $rose(sda)) |=> !sda_d_oe [*4]; endproperty
    a_release_after_stop: assert property (p_release_after_stop) else $error("slave drove after stop");
    property p_start_free; (scl && $fell(sda)) |-> !sda_d_oe; endproperty
    a_start_free: assert property (p_start_free) else $error("slave pulled sda at a start");

    c_write_cycle: cover property ($rose(busy_o));
    c_slave_drive: cover property ($rose(sda_d_oe));
    c_stop: cover property (scl && $rose(sda));
    c_poll_retry: cover property (busy_o && scl && $fell(sda));
endmodule

`default_nettype wire

// ===== tb/test_serial_eeprom_read_and_ack_poll.sv
// self-checking bench: master and slave joined, random writes and reads
// assumes the master makes scl from mclk; memory resets to zero
`timescale 1ns/1ps
`default_nettype none

module test_serial_eeprom_read_and_ack_poll;
    // longer than one control byte, so polls really get refused
    localparam int unsigned WR_CYC = 400;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b1;
    logic cmd_valid_i = 1'b0;
    eeprom_pkg::cmd_type cmd_i = eeprom_pkg::CMD_WRITE;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00;
    logic [3:0] rd_len_i = 4'h0;
    logic cmd_ready_o, rdata_valid_o, done_o, busy_o;
    logic [7:0] rdata_o;
    logic [7:0] mem [16];
    logic [3:0] ptr;
    int error_cnt = 0;
    int check_count = 0;
    int seed = 32'h7ce2;

    i2c_link_if link();
    always #25 mclk_i = ~mclk_i;
    eeprom_master #(.QTR(4)) u_eeprom_master (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .link(link.host),
        .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .addr_i(addr_i), .wdata_i(wdata_i), .rd_len_i(rd_len_i),
        .cmd_ready_o(cmd_ready_o), .rdata_o(rdata_o), .rdata_valid_o(rdata_valid_o), .done_o(done_o));
    eeprom_slave #(.WR_CYCLES(WR_CYC)) u_eeprom_slave (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .link(link.device), .busy_o(busy_o));
    eeprom_link_checker #(.WR_CYCLES(WR_CYC)) u_eeprom_link_checker (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .scl(link.scl), .sda(link.sda), .sda_d_oe(link.sda_d_oe), .busy_o(busy_o));

    // ----------------------------------------------------------------
    // checks, commands and the closing report
    // ----------------------------------------------------------------
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // pointer wraps from the top location back to zero
    function automatic logic [3:0] next_ptr(input logic [3:0] p);
        return p + 4'h1;
    endfunction

    // nacked control bytes are retried by the master, so a busy slave only stretches this
    task automatic do_cmd(input eeprom_pkg::cmd_type c, input logic [3:0] a, input logic [7:0] d,
                          input logic [3:0] len);
        int n;
        int cnt;
        n = 0;
        cnt = 0;
        while (cmd_ready_o !== 1'b1 && n < 100) begin
            @(posedge mclk_i);
            n++;
        end
        if (n >= 100) begin
            error_cnt++;
            summarize();
        end
        cmd_valid_i <= 1'b1;
        cmd_i <= c;
        addr_i <= a;
        wdata_i <= d;
        rd_len_i <= len;
        if (c == eeprom_pkg::CMD_WRITE) begin
            mem[a] = d;
        end
        if (c == eeprom_pkg::CMD_WRITE || c == eeprom_pkg::CMD_READ_RAND) begin
            ptr = a;
        end
        @(posedge mclk_i);
        cmd_valid_i <= 1'b0;
        n = 0;
        while (done_o !== 1'b1 && n < 20000) begin
            @(posedge mclk_i);
            n++;
            if (rdata_valid_o === 1'b1) begin
                chk8(rdata_o, mem[ptr]);
                ptr = next_ptr(ptr);
                cnt++;
            end
        end
        if (n >= 20000) begin
            error_cnt++;
            summarize();
        end
        if (c == eeprom_pkg::CMD_READ_CUR || c == eeprom_pkg::CMD_READ_RAND) begin
            chk8(8'(cnt), 8'(len) + 8'h1);
        end
    endtask

    task automatic write_poll(input logic [3:0] a, input logic [7:0] d);
        int n;
        do_cmd(eeprom_pkg::CMD_WRITE, a, d, 4'h0);
        n = 0;
        while (busy_o !== 1'b1 && n < 20) begin
            @(posedge mclk_i);
            n++;
        end
        chk1(busy_o, 1'b1);
        do_cmd(eeprom_pkg::CMD_POLL, 4'h0, 8'h00, 4'h0);
        chk1(busy_o, 1'b0);
    endtask

    initial begin
        for (int i = 0; i < 16; i++) begin
            mem[i] = 8'h00;
        end
        ptr = 4'h0;
        // a real falling edge: the scl-clocked flops reset only on it
        rst_n_i <= 1'b0;
        repeat (12) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        @(posedge mclk_i);
        do_cmd(eeprom_pkg::CMD_READ_CUR, 4'h0, 8'h00, 4'h1);
        write_poll(4'hF, 8'hA5);
        write_poll(4'h0, 8'h5A);
        for (int i = 0; i < 6; i++) begin
            write_poll(4'($random(seed)), 8'($random(seed)));
        end
        do_cmd(eeprom_pkg::CMD_READ_RAND, 4'hE, 8'h00, 4'h3);
        do_cmd(eeprom_pkg::CMD_READ_CUR, 4'h0, 8'h00, 4'h0);
        do_cmd(eeprom_pkg::CMD_READ_RAND, 4'h0, 8'h00, 4'hF);
        for (int i = 0; i < 6; i++) begin
            do_cmd(($random(seed) & 1) ? eeprom_pkg::CMD_READ_RAND : eeprom_pkg::CMD_READ_CUR,
                   4'($random(seed)), 8'h00, 4'($random(seed)));
        end
        // read straight after a write: control bytes are refused until the cycle ends
        do_cmd(eeprom_pkg::CMD_WRITE, 4'h7, 8'h3C, 4'h0);
        do_cmd(eeprom_pkg::CMD_READ_CUR, 4'h0, 8'h00, 4'h2);
        summarize();
    end
endmodule

`default_nettype wire
